/* File: hdl/ufc_pkg.sv */
// register map, field positions, reset values and timing for the uart frame/status block
// assumes a 40 MHz controller clock and a fixed line rate
package ufc_pkg;
   localparam logic [15:0] ADDR_DATA = 16'h44A0;
   localparam logic [15:0] ADDR_STAT = 16'h44A4;
   localparam logic [15:0] ADDR_CFG = 16'h44A8;
   localparam logic [15:0] ADDR_IST = 16'h44C0;
   localparam logic [15:0] ADDR_IMASK = 16'h44C4;
   localparam int CFG_RTS = 0;
   localparam int CFG_8BIT = 1;
   localparam int CFG_2STP = 2;
   localparam int CFG_PAR = 3;
   localparam int CFG_ODD = 4;
   localparam logic [4:0] CFG_RST = 5'h00;
   localparam int ST_RXVAL = 1;
   localparam int ST_TXFREE = 2;
   localparam int ST_PARERR = 5;
   localparam int ST_TXIDLE = 6;
   localparam int IRQ_RX = 0;
   localparam int IRQ_PERR = 1;
   localparam int IRQ_TXIDLE = 2;
   localparam logic [2:0] IRQ_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CLK_PS = 25000;
   localparam int BIT_PS = 8680000;
   localparam logic [8:0] BIT_CYC = 9'(BIT_PS / CLK_PS);
   localparam logic [8:0] HALF_CYC = 9'(BIT_PS / CLK_PS / 2);
   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ufc_ser_st_t;
endpackage : ufc_pkg

/* File: hdl/ufc_rx.sv */
// serial character receiver: start, 7/8 data bits lsb first, optional parity, stop
// assumes rxd idles high; the line is synchronised here
`timescale 1ns/1ps
module ufc_rx
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // line and frame format
   input wire logic rxd,
   input wire logic eight_bit_select,
   input wire logic parity_enable,
   input wire logic odd_parity_select,
   // character out
   output logic done,
   output logic [7:0] data,
   output logic par_err
);
   logic rxd_m_ff, rxd_s_ff;
   ufc_pkg::ufc_ser_st_t st_ff;
   logic [8:0] cnt_ff;
   logic [2:0] bit_ff;
   logic [7:0] sh_ff;
   logic par_ff;
   wire tick = cnt_ff == 9'h000;
   wire [2:0] last_bit = eight_bit_select ? 3'h7 : 3'h6;
   wire [7:0] rx_char = eight_bit_select ? sh_ff : {1'b0, sh_ff[7:1]};
   // parity covers the data bits only, the received parity bit closes the sum
   wire par_bad = parity_enable & ((^rx_char) ^ par_ff ^ odd_parity_select);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxd_m_ff <= 1'b1;
         rxd_s_ff <= 1'b1;
      end
      else
      begin
         rxd_m_ff <= rxd;
         rxd_s_ff <= rxd_m_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= ufc_pkg::S_IDLE;
         cnt_ff <= 9'h000;
         bit_ff <= 3'h0;
         sh_ff <= 8'h00;
         par_ff <= 1'b0;
         done <= 1'b0;
         data <= 8'h00;
         par_err <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (!tick)
            cnt_ff <= cnt_ff - 9'h001;
         case (st_ff)
            ufc_pkg::S_IDLE:
               if (!rxd_s_ff)
               begin
                  st_ff <= ufc_pkg::S_START;
                  cnt_ff <= ufc_pkg::HALF_CYC;
               end
            ufc_pkg::S_START:
               if (tick)
               begin
                  // a glitch shorter than half a bit is not a start
                  st_ff <= rxd_s_ff ? ufc_pkg::S_IDLE : ufc_pkg::S_DATA;
                  cnt_ff <= ufc_pkg::BIT_CYC - 9'h001;
                  bit_ff <= 3'h0;
               end
            ufc_pkg::S_DATA:
               if (tick)
               begin
                  sh_ff <= {rxd_s_ff, sh_ff[7:1]};
                  bit_ff <= bit_ff + 3'h1;
                  cnt_ff <= ufc_pkg::BIT_CYC - 9'h001;
                  if (bit_ff == last_bit)
                     st_ff <= parity_enable ? ufc_pkg::S_PAR : ufc_pkg::S_STOP;
               end
            ufc_pkg::S_PAR:
               if (tick)
               begin
                  par_ff <= rxd_s_ff;
                  cnt_ff <= ufc_pkg::BIT_CYC - 9'h001;
                  st_ff <= ufc_pkg::S_STOP;
               end
            ufc_pkg::S_STOP:
               if (tick)
               begin
                  // the line is not checked here, the character ends mid first stop bit, so one or two both receive
                  done <= 1'b1;
                  data <= rx_char;
                  par_err <= par_bad;
                  st_ff <= ufc_pkg::S_IDLE;
               end
            default:
               st_ff <= ufc_pkg::S_IDLE;
         endcase
      end
   end
endmodule : ufc_rx

/* File: hdl/ufc_top.sv */
// uart frame format, line status and character path behind an axi4-lite slave
// assumes a single 40 MHz clock, a peer at the fixed line rate, one bus master
// Function
// - config bit 0 set drives request line low
// - status bit 6 shows transmitter idle, resets one
// - status bit 5 set on received parity mismatch
// - reading receive data clears parity error flag
// - config bit 4 selects odd, else even
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module ufc_top
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   // axi4-lite write
   input wire logic [15:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read
   input wire logic [15:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // serial line
   output logic UART_TXD,
   input wire logic UART_RXD,
   output logic REQUEST_TO_SEND_N,
   // interrupt
   output logic IRQ
);
   logic [15:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic aw_ok_ff, w_ok_ff;
   logic [4:0] cfg_ff;
   logic [2:0] ist_ff, imask_ff;
   logic [7:0] tx_buf_ff, rx_buf_ff, tx_sh_ff;
   logic tx_full_ff, rx_val_ff, parerr_ff, tx_par_ff, idle_d_ff;
   ufc_pkg::ufc_ser_st_t tx_st_ff;
   logic [8:0] tx_cnt_ff;
   logic [2:0] tx_bit_ff;
   logic rx_done, rx_perr;
   logic [7:0] rx_data;

   // bus decode
   wire wr_go = aw_ok_ff & w_ok_ff & ~S_AXI_BVALID;
   wire wr_lo = wstrb_ff[0];
   wire wr_data = wr_go & wr_lo & (awaddr_ff == ufc_pkg::ADDR_DATA);
   wire wr_cfg = wr_go & wr_lo & (awaddr_ff == ufc_pkg::ADDR_CFG);
   wire wr_imask = wr_go & wr_lo & (awaddr_ff == ufc_pkg::ADDR_IMASK);
   wire wr_hit = (awaddr_ff == ufc_pkg::ADDR_DATA) | (awaddr_ff == ufc_pkg::ADDR_CFG)
      | (awaddr_ff == ufc_pkg::ADDR_IMASK) | (awaddr_ff == ufc_pkg::ADDR_STAT)
      | (awaddr_ff == ufc_pkg::ADDR_IST);
   wire rd_go = S_AXI_ARVALID & S_AXI_ARREADY;
   wire rd_data = rd_go & (S_AXI_ARADDR == ufc_pkg::ADDR_DATA);
   wire rd_ist = rd_go & (S_AXI_ARADDR == ufc_pkg::ADDR_IST);

   // status and read mux
   wire tx_idle = ~tx_full_ff & (tx_st_ff == ufc_pkg::S_IDLE);
   // each flag is widened before its shift so that no bit lands off its own position
   wire [15:0] stat = ({15'h0000, tx_idle} << ufc_pkg::ST_TXIDLE)
      | ({15'h0000, parerr_ff} << ufc_pkg::ST_PARERR)
      | ({15'h0000, ~tx_full_ff} << ufc_pkg::ST_TXFREE)
      | ({15'h0000, rx_val_ff} << ufc_pkg::ST_RXVAL);
   wire rd_hit = (S_AXI_ARADDR == ufc_pkg::ADDR_DATA) | (S_AXI_ARADDR == ufc_pkg::ADDR_STAT)
      | (S_AXI_ARADDR == ufc_pkg::ADDR_CFG) | (S_AXI_ARADDR == ufc_pkg::ADDR_IST)
      | (S_AXI_ARADDR == ufc_pkg::ADDR_IMASK);
   wire [31:0] rd_mux =
      (S_AXI_ARADDR == ufc_pkg::ADDR_DATA) ? {24'h000000, rx_buf_ff} :
      (S_AXI_ARADDR == ufc_pkg::ADDR_STAT) ? {16'h0000, stat} :
      (S_AXI_ARADDR == ufc_pkg::ADDR_CFG) ? {27'h0000000, cfg_ff} :
      (S_AXI_ARADDR == ufc_pkg::ADDR_IST) ? {29'h00000000, ist_ff} :
      (S_AXI_ARADDR == ufc_pkg::ADDR_IMASK) ? {29'h00000000, imask_ff} : 32'h00000000;

   // events; a set in the same cycle as the clearing read wins
   wire [2:0] ev = {tx_idle & ~idle_d_ff, rx_done & rx_perr, rx_done};
   wire [2:0] nxt_ist = (rd_ist ? 3'h0 : ist_ff) | ev;
   wire nxt_parerr = (rx_done & rx_perr) | (parerr_ff & ~rd_data);
   // the interrupt follows a mask write in the same cycle as the status
   wire [2:0] nxt_imask = wr_imask ? wdata_ff[2:0] : imask_ff;
   wire tx_take = (tx_st_ff == ufc_pkg::S_IDLE) & tx_full_ff;
   wire tx_tick = tx_cnt_ff == 9'h000;
   wire [2:0] tx_last = cfg_ff[ufc_pkg::CFG_8BIT] ? 3'h7 : 3'h6;
   wire [7:0] tx_char = cfg_ff[ufc_pkg::CFG_8BIT] ? tx_buf_ff : {1'b0, tx_buf_ff[6:0]};

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY <= 1'b1;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= ufc_pkg::RESP_OKAY;
         aw_ok_ff <= 1'b0;
         w_ok_ff <= 1'b0;
         awaddr_ff <= 16'h0000;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
      end
      else
      begin
         if (S_AXI_AWVALID & S_AXI_AWREADY)
         begin
            awaddr_ff <= S_AXI_AWADDR;
            aw_ok_ff <= 1'b1;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID & S_AXI_WREADY)
         begin
            wdata_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
            w_ok_ff <= 1'b1;
            S_AXI_WREADY <= 1'b0;
         end
         if (wr_go)
         begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? ufc_pkg::RESP_OKAY : ufc_pkg::RESP_SLVERR;
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
         end
         if (S_AXI_BVALID & S_AXI_BREADY)
         begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= ufc_pkg::RESP_OKAY;
      end
      else if (rd_go)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_mux;
         S_AXI_RRESP <= rd_hit ? ufc_pkg::RESP_OKAY : ufc_pkg::RESP_SLVERR;
      end
      else if (S_AXI_RVALID & S_AXI_RREADY)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // registers, flags, request line and interrupt
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         cfg_ff <= ufc_pkg::CFG_RST;
         imask_ff <= ufc_pkg::IRQ_RST;
         ist_ff <= ufc_pkg::IRQ_RST;
         tx_buf_ff <= 8'h00;
         tx_full_ff <= 1'b0;
         rx_buf_ff <= 8'h00;
         rx_val_ff <= 1'b0;
         parerr_ff <= 1'b0;
         idle_d_ff <= 1'b1;
         REQUEST_TO_SEND_N <= 1'b1;
         IRQ <= 1'b0;
      end
      else
      begin
         if (wr_cfg)
            cfg_ff <= wdata_ff[4:0];
         if (wr_imask)
            imask_ff <= wdata_ff[2:0];
         // a write while the holding byte is still full is dropped; poll bit 2 first
         if (wr_data & ~tx_full_ff)
            tx_buf_ff <= wdata_ff[7:0];
         // a dropped write must not mark the byte being taken as still waiting
         tx_full_ff <= (tx_full_ff & ~tx_take) | (wr_data & ~tx_full_ff);
         if (rx_done)
            rx_buf_ff <= rx_data;
         rx_val_ff <= rx_done | (rx_val_ff & ~rd_data);
         parerr_ff <= nxt_parerr;
         ist_ff <= nxt_ist;
         idle_d_ff <= tx_idle;
         REQUEST_TO_SEND_N <= ~cfg_ff[ufc_pkg::CFG_RTS];
         IRQ <= |(nxt_ist & nxt_imask);
      end
   end

   // transmitter: config is used live, so change it only while idle
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         tx_st_ff <= ufc_pkg::S_IDLE;
         tx_cnt_ff <= 9'h000;
         tx_bit_ff <= 3'h0;
         tx_sh_ff <= 8'h00;
         tx_par_ff <= 1'b0;
         UART_TXD <= 1'b1;
      end
      else
      begin
         if (!tx_tick)
            tx_cnt_ff <= tx_cnt_ff - 9'h001;
         case (tx_st_ff)
            ufc_pkg::S_IDLE:
               if (tx_take)
               begin
                  tx_sh_ff <= tx_char;
                  tx_par_ff <= (^tx_char) ^ cfg_ff[ufc_pkg::CFG_ODD];
                  tx_cnt_ff <= ufc_pkg::BIT_CYC - 9'h001;
                  tx_st_ff <= ufc_pkg::S_START;
               end
            ufc_pkg::S_START:
               if (tx_tick)
               begin
                  tx_bit_ff <= 3'h0;
                  tx_cnt_ff <= ufc_pkg::BIT_CYC - 9'h001;
                  tx_st_ff <= ufc_pkg::S_DATA;
               end
            ufc_pkg::S_DATA:
               if (tx_tick)
               begin
                  tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                  tx_bit_ff <= tx_bit_ff + 3'h1;
                  tx_cnt_ff <= ufc_pkg::BIT_CYC - 9'h001;
                  if (tx_bit_ff == tx_last)
                  begin
                     tx_bit_ff <= 3'h0;
                     tx_st_ff <= cfg_ff[ufc_pkg::CFG_PAR] ? ufc_pkg::S_PAR
                        : ufc_pkg::S_STOP;
                  end
               end
            ufc_pkg::S_PAR:
               if (tx_tick)
               begin
                  tx_cnt_ff <= ufc_pkg::BIT_CYC - 9'h001;
                  tx_st_ff <= ufc_pkg::S_STOP;
               end
            ufc_pkg::S_STOP:
               if (tx_tick)
               begin
                  if (cfg_ff[ufc_pkg::CFG_2STP] && tx_bit_ff == 3'h0)
                  begin
                     tx_bit_ff <= 3'h1;
                     tx_cnt_ff <= ufc_pkg::BIT_CYC - 9'h001;
                  end
                  else
                     tx_st_ff <= ufc_pkg::S_IDLE;
               end
            default:
               tx_st_ff <= ufc_pkg::S_IDLE;
         endcase
         UART_TXD <= (tx_st_ff == ufc_pkg::S_START) ? 1'b0 :
            (tx_st_ff == ufc_pkg::S_DATA) ? tx_sh_ff[0] :
            (tx_st_ff == ufc_pkg::S_PAR) ? tx_par_ff : 1'b1;
      end
   end

   ufc_rx u_rx
   (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .rxd(UART_RXD),
      .eight_bit_select(cfg_ff[ufc_pkg::CFG_8BIT]),
      .parity_enable(cfg_ff[ufc_pkg::CFG_PAR]),
      .odd_parity_select(cfg_ff[ufc_pkg::CFG_ODD]),
      .done(rx_done),
      .data(rx_data),
      .par_err(rx_perr)
   );

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   a_rts_assert_low: assert property (cfg_ff[0] |=> !REQUEST_TO_SEND_N)
      else $error("request line not low while enabled");
   a_rts_release_high: assert property (!cfg_ff[0] |=> REQUEST_TO_SEND_N)
      else $error("request line not high while disabled");
   a_idle_when_busy: assert property (tx_st_ff != ufc_pkg::S_IDLE |-> !stat[6])
      else $error("idle flag set while shifting");
   a_perr_set: assert property (rx_done && rx_perr |=> stat[5])
      else $error("parity error flag missed");
   a_perr_read_clr: assert property (rd_data && !(rx_done && rx_perr) |=> !parerr_ff)
      else $error("parity error flag not cleared by data read");
   a_start_bit_low: assert property ($rose(tx_st_ff == ufc_pkg::S_START) |=> !UART_TXD)
      else $error("start bit not low");
   a_data_bit_count: assert property (tx_st_ff == ufc_pkg::S_DATA && tx_tick
      && tx_bit_ff == tx_last |=> tx_st_ff == (cfg_ff[3] ? ufc_pkg::S_PAR : ufc_pkg::S_STOP))
      else $error("wrong data bit count");
   a_parity_bit_value: assert property (tx_st_ff == ufc_pkg::S_PAR |=> UART_TXD == tx_par_ff)
      else $error("parity bit wrong on line");
   a_two_stop_len: assert property (tx_st_ff == ufc_pkg::S_STOP && tx_tick && cfg_ff[2]
      && tx_bit_ff == 3'h0 |=> tx_st_ff == ufc_pkg::S_STOP)
      else $error("second stop bit skipped");
   a_irq_follow: assert property ((ist_ff & imask_ff) != 3'h0 |-> IRQ)
      else $error("interrupt low with unmasked status");
   c_parity_error: cover property (rx_done && rx_perr);
   c_two_stop_frame: cover property (tx_st_ff == ufc_pkg::S_STOP && tx_bit_ff == 3'h1);
   c_data_read: cover property (rd_data && rx_val_ff);
endmodule : ufc_top

/* File: bench/ufc_peer.sv */
// serial peer: sends frames into the device and decodes the frames the device sends
// assumes the frame format is handed in as the device's config bits, line idles high
`timescale 1ns/1ps
module ufc_peer
(
   // clock
   input wire logic clk,
   // line
   input wire logic txd,
   input wire logic rts_n,
   output logic rxd,
   // control and capture
   input wire logic [4:0] cfg,
   input wire logic go,
   input wire logic [7:0] tx_byte,
   input wire logic bad_par,
   output logic busy,
   output logic [7:0] cap_byte,
   output logic cap_par,
   output logic cap_stop,
   output int cap_cnt
);
   logic [7:0] msk;
   logic par_bit;

   assign msk = cfg[ufc_pkg::CFG_8BIT] ? 8'hFF : 8'h7F;
   assign par_bit = ^(tx_byte & msk) ^ cfg[ufc_pkg::CFG_ODD] ^ bad_par;

   task automatic put(input logic b);
      rxd <= b;
      repeat (ufc_pkg::BIT_CYC) @(posedge clk);
   endtask : put

   task automatic get(output logic b);
      repeat (ufc_pkg::BIT_CYC) @(posedge clk);
      b = txd;
   endtask : get

   initial
   begin
      rxd = 1'b1;
      busy = 1'b0;
      forever
      begin
         @(posedge clk);
         if (go === 1'b1)
         begin
            busy <= 1'b1;
            // a request stays queued until the device lowers its request line
            while (rts_n !== 1'b0) @(posedge clk);
            put(1'b0);
            for (int i = 0; i < 8; i++)
               if (msk[i])
                  put(tx_byte[i]);
            if (cfg[ufc_pkg::CFG_PAR])
               put(par_bit);
            put(1'b1);
            if (cfg[ufc_pkg::CFG_2STP])
               put(1'b1);
            busy <= 1'b0;
         end
      end
   end

   // decoder samples mid-bit and reports at the middle of the last stop bit
   initial
   begin
      logic [7:0] b;
      logic p;
      logic s;
      cap_cnt = 0;
      forever
      begin
         @(negedge txd);
         repeat (ufc_pkg::HALF_CYC) @(posedge clk);
         b = 8'h00;
         p = 1'b0;
         for (int i = 0; i < 8; i++)
            if (msk[i])
               get(b[i]);
         if (cfg[ufc_pkg::CFG_PAR])
            get(p);
         get(s);
         cap_stop = s;
         if (cfg[ufc_pkg::CFG_2STP])
            get(s);
         cap_stop = cap_stop & s;
         cap_byte = b;
         cap_par = p;
         cap_cnt++;
      end
   end
endmodule : ufc_peer

/* File: bench/tb.sv */
// self-checking bench: register access, transmit framing per format, receive with parity
// assumes ufc_top on axi4-lite and ufc_peer on the serial line
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] TXI = 32'h1 << ufc_pkg::ST_TXIDLE;
   localparam logic [31:0] ST0 = TXI | (32'h1 << ufc_pkg::ST_TXFREE);
   localparam logic [31:0] RXV = 32'h1 << ufc_pkg::ST_RXVAL;
   localparam logic [31:0] PER = 32'h1 << ufc_pkg::ST_PARERR;
   localparam logic [4:0] FMT [5] = '{5'h02, 5'h00, 5'h0E, 5'h1A, 5'h18};
   localparam logic [7:0] VAL [5] = '{8'hA5, 8'hC3, 8'h5A, 8'h81, 8'hFE};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] awaddr = 16'h0000;
   logic [15:0] araddr = 16'h0000;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, txd, rxd, rts_n, irq, busy;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [4:0] cfg = 5'h00;
   logic go = 1'b0;
   logic bad = 1'b0;
   logic [7:0] pbyte = 8'h00;
   logic [7:0] cap_byte, m;
   logic cap_par, cap_stop;
   int cap_cnt;
   int n_fail = 0;
   int cmp_count = 0;

   ufc_top dut
   (
      .REF_CLK(clk), .RESETN(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .UART_TXD(txd), .UART_RXD(rxd), .REQUEST_TO_SEND_N(rts_n), .IRQ(irq)
   );

   ufc_peer peer
   (
      .clk(clk), .txd(txd), .rts_n(rts_n), .rxd(rxd), .cfg(cfg), .go(go), .tx_byte(pbyte),
      .bad_par(bad), .busy(busy), .cap_byte(cap_byte), .cap_par(cap_par),
      .cap_stop(cap_stop), .cap_cnt(cap_cnt)
   );

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge clk);
         if (awvalid && awready === 1'b1)
         begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1)
         begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [15:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd

   task automatic wcfg(input logic [4:0] v);
      wr(ufc_pkg::ADDR_CFG, {27'h0, v});
      chk(r, ufc_pkg::RESP_OKAY);
      cfg <= v;
   endtask : wcfg

   task automatic send(input logic [7:0] b, input logic e);
      pbyte <= b;
      bad <= e;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask : send

   // busy is raised one edge after the request, so let it land first
   task automatic peer_wait();
      repeat (2) @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
   endtask : peer_wait

   initial
   begin
      #1500000;
      n_fail++;
      close_out();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(ufc_pkg::ADDR_STAT);
      chk(d, ST0);
      chk(r, ufc_pkg::RESP_OKAY);
      rd(16'h4400);
      chk(r, ufc_pkg::RESP_SLVERR);
      chk(d, 32'h0);
      wr(16'h4400, 32'h1);
      chk(r, ufc_pkg::RESP_SLVERR);
      wcfg(5'h01);
      chk(rts_n, 1'b0);
      wcfg(5'h00);
      chk(rts_n, 1'b1);
      for (int k = 0; k < 5; k++)
      begin
         wcfg(FMT[k]);
         m = FMT[k][ufc_pkg::CFG_8BIT] ? 8'hFF : 8'h7F;
         wr(ufc_pkg::ADDR_DATA, {24'h0, VAL[k]});
         rd(ufc_pkg::ADDR_STAT);
         chk(d & TXI, 32'h0);
         while (cap_cnt != k + 1) @(posedge clk);
         chk(cap_byte, VAL[k] & m);
         chk(cap_par, FMT[k][ufc_pkg::CFG_PAR] & (^(VAL[k] & m) ^ FMT[k][ufc_pkg::CFG_ODD]));
         chk(cap_stop, 1'b1);
         // still inside the last stop bit, then one bit time later the line is idle
         rd(ufc_pkg::ADDR_STAT);
         chk(d & TXI, 32'h0);
         repeat (ufc_pkg::BIT_CYC) @(posedge clk);
         rd(ufc_pkg::ADDR_STAT);
         chk(d & TXI, TXI);
      end
      wr(ufc_pkg::ADDR_IMASK, 32'h1 << ufc_pkg::IRQ_PERR);
      wcfg(5'h1A);
      send(8'h3C, 1'b0);
      repeat (700) @(posedge clk);
      rd(ufc_pkg::ADDR_STAT);
      chk(d & RXV, 32'h0);
      wcfg(5'h1B);
      peer_wait();
      rd(ufc_pkg::ADDR_STAT);
      chk(d, ST0 | RXV);
      chk(irq, 1'b0);
      rd(ufc_pkg::ADDR_DATA);
      chk(d, 32'h3C);
      // seven bits, two stops, even parity for the corrupted character
      wcfg(5'h0D);
      send(8'h96, 1'b1);
      peer_wait();
      rd(ufc_pkg::ADDR_STAT);
      chk(d, ST0 | RXV | PER);
      chk(irq, 1'b1);
      rd(ufc_pkg::ADDR_DATA);
      chk(d, 32'h96 & 32'h7F);
      rd(ufc_pkg::ADDR_STAT);
      chk(d, ST0);
      rd(ufc_pkg::ADDR_IST);
      chk(d, 32'h7);
      chk(irq, 1'b0);
      close_out();
   end
endmodule : tb
